// File: phy_mac_pkg.sv
// Constants, modes and symbol and word types for the PHY MAC-side interface.
// Assumes one 40 MHz system clock; interface clocks are modelled by dividers.
package phy_mac_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int HZ_10 = 2_500_000;
   localparam int HZ_100 = 25_000_000;
   localparam int HZ_1000 = 125_000_000;
   localparam int DIV_10 = CLK_HZ / (2 * HZ_10);
   localparam int DIV_100 = CLK_HZ / (2 * HZ_100);
   localparam int DIV_1000 = CLK_HZ / (2 * HZ_1000);
   // Half periods in system cycles, never below one cycle.
   localparam logic [7:0] HALF_10 = (DIV_10 < 1) ? 8'h01 : 8'(DIV_10);
   localparam logic [7:0] HALF_100 = (DIV_100 < 1) ? 8'h01 : 8'(DIV_100);
   localparam logic [7:0] HALF_1000 = (DIV_1000 < 1) ? 8'h01 : 8'(DIV_1000);
   localparam int RX_FIFO_DEPTH = 16;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [3:0] NIB_ZERO = 4'h0;

   typedef enum logic [2:0] {
      MODE_MII = 3'b001,
      MODE_GMII = 3'b010,
      MODE_RGMII = 3'b100
   } if_mode_e;

   typedef enum logic [2:0] {
      SPD_10 = 3'b001,
      SPD_100 = 3'b010,
      SPD_1000 = 3'b100
   } speed_e;

   typedef enum logic [2:0] {
      SYM_DATA = 3'b001,
      SYM_INVALID = 3'b010,
      SYM_HALT = 3'b100
   } sym_kind_e;

   typedef struct packed {
      logic err;
      logic [7:0] data;
   } rx_word_s;

   typedef struct packed {
      sym_kind_e kind;
      logic [7:0] data;
      logic nibble;
   } tx_sym_s;

   typedef struct packed {
      logic clk;
      logic [7:0] d;
      logic en;
      logic er;
   } tx_pins_s;

   localparam tx_sym_s TX_SYM_RST = '{kind: SYM_DATA, data: DATA_RST, nibble: 1'b0};
endpackage

// File: phy_mac_side_interface.sv
// MAC-facing transmit sampler, receive driver and status pins of the PHY.
// Assumes config inputs and the line-side stream are on clk_i; MAC pins are not.
`timescale 1ns/1ps

// Receive word buffer between the line side and the MAC receive pins.
module rx_word_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Filling side.
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // Draining side.
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   logic [AW:0] nxt_cnt;
   logic ready_ff;
   logic push;
   logic pop;

   // Ready is registered from the next count so it never lags a fill.
   assign in_ready_o = ready_ff;
   assign push = in_valid_i & ready_ff;
   assign out_valid_o = (cnt_ff != '0);
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem_ff[rd_ff];

   // Occupancy after this cycle's push and pop.
   always_comb begin
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Storage needs no reset; the count guards every read.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data_i;
      end
   end

   // Pointers wrap explicitly so any depth works.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
         ready_ff <= 1'b0;
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= nxt_cnt;
         ready_ff <= (nxt_cnt < DEPTH);
      end
   end
endmodule // rx_word_fifo

module phy_mac_side_interface #(
   parameter int RX_DEPTH = phy_mac_pkg::RX_FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Configuration.
   input wire phy_mac_pkg::if_mode_e mode_i,
   input wire phy_mac_pkg::speed_e speed_i,
   input wire logic full_duplex_i,
   // MAC transmit pins.
   input wire logic gtx_clk_i,
   input wire logic [7:0] txd_i,
   input wire logic tx_ctl_i,
   input wire logic tx_er_i,
   output logic tx_clk_o,
   // MAC receive and status pins.
   output logic rx_clk_o,
   output logic [7:0] rxd_o,
   output logic rx_ctl_o,
   output logic rx_er_o,
   output logic col_o,
   output logic crs_o,
   // Line-side transmit symbols.
   output logic tx_sym_valid_o,
   output phy_mac_pkg::tx_sym_s tx_sym_o,
   // Line-side receive words.
   input wire logic line_rx_valid_i,
   input wire phy_mac_pkg::rx_word_s line_rx_word_i,
   output logic line_rx_ready_o
);
   phy_mac_pkg::tx_pins_s pin_s1_ff;
   phy_mac_pkg::tx_pins_s pin_s2_ff;
   phy_mac_pkg::tx_pins_s pin_s3_ff;
   phy_mac_pkg::tx_sym_s sym_ff;
   phy_mac_pkg::rx_word_s rq;
   phy_mac_pkg::rx_word_s cur_ff;
   phy_mac_pkg::sym_kind_e nxt_kind;
   logic is_mii, is_gmii, is_rgmii, mac_pins;
   logic gtx_rise, gtx_fall;
   logic [7:0] half_now;
   logic [7:0] tx_cnt_ff, rx_cnt_ff;
   logic tx_clk_ff, rx_clk_ff;
   logic tx_tick, rx_tick, mii_rise, rx_rise, rx_fall;
   logic [3:0] rg_lo_ff;
   logic rg_ctl_r_ff;
   logic u_fire, u_en, u_er, u_nib;
   logic [7:0] u_data;
   logic sym_valid_ff, err_seen_ff, tx_act_ff;
   logic [7:0] rxd_ff;
   logic rx_ctl_ff, rx_er_ff, cur_ok_ff, nib_ff;
   logic col_ff, crs_ff;
   logic rq_valid, rx_pop;

   assign is_mii = (mode_i == phy_mac_pkg::MODE_MII);
   assign is_gmii = (mode_i == phy_mac_pkg::MODE_GMII);
   assign is_rgmii = (mode_i == phy_mac_pkg::MODE_RGMII);
   assign mac_pins = is_mii | is_gmii;

   // Half period of the interface clocks for the current speed.
   always_comb begin
      unique case (speed_i)
         phy_mac_pkg::SPD_10: half_now = phy_mac_pkg::HALF_10;
         phy_mac_pkg::SPD_100: half_now = phy_mac_pkg::HALF_100;
         phy_mac_pkg::SPD_1000: half_now = phy_mac_pkg::HALF_1000;
         default: half_now = phy_mac_pkg::HALF_100;
      endcase
   end

   // MAC pins cross in through two flops; stage three only feeds edge and data picks.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         pin_s3_ff <= '0;
      end else begin
         pin_s1_ff <= {gtx_clk_i, txd_i, tx_ctl_i, tx_er_i};
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end

   // Data is taken from the stage before the edge, so it predates the edge.
   assign gtx_rise = pin_s2_ff.clk & ~pin_s3_ff.clk;
   assign gtx_fall = ~pin_s2_ff.clk & pin_s3_ff.clk;

   // MII transmit clock runs only in MII and sits low otherwise.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         tx_cnt_ff <= '0;
         tx_clk_ff <= 1'b0;
      end else if (!is_mii) begin
         tx_cnt_ff <= '0;
         tx_clk_ff <= 1'b0;
      end else if (tx_cnt_ff == '0) begin
         tx_cnt_ff <= half_now - 8'h01;
         tx_clk_ff <= ~tx_clk_ff;
      end else begin
         tx_cnt_ff <= tx_cnt_ff - 8'h01;
      end
   end

   assign tx_tick = is_mii & (tx_cnt_ff == '0);
   assign mii_rise = tx_tick & ~tx_clk_ff;

   // Receive clock is free running in every mode.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rx_cnt_ff <= '0;
         rx_clk_ff <= 1'b0;
      end else if (rx_cnt_ff == '0) begin
         rx_cnt_ff <= half_now - 8'h01;
         rx_clk_ff <= ~rx_clk_ff;
      end else begin
         rx_cnt_ff <= rx_cnt_ff - 8'h01;
      end
   end

   assign rx_tick = (rx_cnt_ff == '0);
   assign rx_rise = rx_tick & ~rx_clk_ff;
   assign rx_fall = rx_tick & rx_clk_ff;

   // RGMII first half: low nibble and enable on the rising edge.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rg_lo_ff <= phy_mac_pkg::NIB_ZERO;
         rg_ctl_r_ff <= 1'b0;
      end else if (gtx_rise & is_rgmii) begin
         rg_lo_ff <= pin_s3_ff.d[3:0];
         rg_ctl_r_ff <= pin_s3_ff.en;
      end
   end

   // One transmit unit per sampling edge of the mode's clock.
   always_comb begin
      u_fire = 1'b0;
      u_en = pin_s3_ff.en;
      u_er = pin_s3_ff.er;
      u_data = pin_s3_ff.d;
      u_nib = 1'b0;
      unique case (mode_i)
         phy_mac_pkg::MODE_MII: begin
            u_fire = mii_rise;
            u_data = {phy_mac_pkg::NIB_ZERO, pin_s3_ff.d[3:0]};
            u_nib = 1'b1;
         end
         phy_mac_pkg::MODE_GMII: begin
            u_fire = gtx_rise;
         end
         phy_mac_pkg::MODE_RGMII: begin
            u_fire = gtx_fall;
            u_en = rg_ctl_r_ff;
            u_er = rg_ctl_r_ff ^ pin_s3_ff.en;
            u_data = {pin_s3_ff.d[3:0], rg_lo_ff};
         end
         default: u_fire = 1'b0;
      endcase
   end

   // In MII the first errored nibble is invalid, the rest are Halt.
   always_comb begin
      if (!u_er) begin
         nxt_kind = phy_mac_pkg::SYM_DATA;
      end else if (is_mii & err_seen_ff) begin
         nxt_kind = phy_mac_pkg::SYM_HALT;
      end else begin
         nxt_kind = phy_mac_pkg::SYM_INVALID;
      end
   end

   // Error with enable low is carrier extension and sends nothing.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sym_valid_ff <= 1'b0;
         sym_ff <= phy_mac_pkg::TX_SYM_RST;
      end else begin
         sym_valid_ff <= u_fire & u_en;
         if (u_fire & u_en) begin
            sym_ff <= '{kind: nxt_kind, data: u_data, nibble: u_nib};
         end
      end
   end

   // Error history and transmit activity per unit.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         err_seen_ff <= 1'b0;
         tx_act_ff <= 1'b0;
      end else if (u_fire) begin
         err_seen_ff <= u_en & u_er;
         tx_act_ff <= u_en;
      end
   end

   rx_word_fifo #(
      .W($bits(phy_mac_pkg::rx_word_s)),
      .DEPTH(RX_DEPTH)
   ) u_rx_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(line_rx_valid_i),
      .in_data_i(line_rx_word_i),
      .in_ready_o(line_rx_ready_o),
      .out_valid_o(rq_valid),
      .out_data_o(rq),
      .out_ready_i(rx_pop)
   );

   // A word leaves the buffer each receive period; MII takes two periods.
   assign rx_pop = rx_fall & (is_gmii | is_rgmii | (is_mii & ~nib_ff));

   // Outputs change half a period before the edge that samples them.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rxd_ff <= phy_mac_pkg::DATA_RST;
         rx_ctl_ff <= 1'b0;
         rx_er_ff <= 1'b0;
         cur_ff <= '0;
         cur_ok_ff <= 1'b0;
         nib_ff <= 1'b0;
      end else begin
         if (rx_fall) begin
            unique case (mode_i)
               phy_mac_pkg::MODE_GMII: begin
                  rxd_ff <= rq.data;
                  rx_ctl_ff <= rq_valid;
                  rx_er_ff <= rq_valid & rq.err;
               end
               phy_mac_pkg::MODE_MII: begin
                  if (nib_ff) begin
                     rxd_ff <= {phy_mac_pkg::NIB_ZERO, cur_ff.data[7:4]};
                     rx_ctl_ff <= cur_ok_ff;
                     rx_er_ff <= cur_ok_ff & cur_ff.err;
                     nib_ff <= 1'b0;
                  end else begin
                     rxd_ff <= {phy_mac_pkg::NIB_ZERO, rq.data[3:0]};
                     rx_ctl_ff <= rq_valid;
                     rx_er_ff <= rq_valid & rq.err;
                     cur_ff <= rq;
                     cur_ok_ff <= rq_valid;
                     nib_ff <= rq_valid;
                  end
               end
               phy_mac_pkg::MODE_RGMII: begin
                  rxd_ff <= {phy_mac_pkg::NIB_ZERO, rq.data[3:0]};
                  rx_ctl_ff <= rq_valid;
                  cur_ff <= rq;
                  cur_ok_ff <= rq_valid;
               end
               default: rx_ctl_ff <= 1'b0;
            endcase
         end else if (rx_rise & is_rgmii) begin
            rxd_ff <= {phy_mac_pkg::NIB_ZERO, cur_ff.data[7:4]};
            rx_ctl_ff <= cur_ok_ff ^ (cur_ok_ff & cur_ff.err);
         end
         // Stale GMII bits must not linger after a mode change.
         if (!is_gmii) begin
            rxd_ff[7:4] <= phy_mac_pkg::NIB_ZERO;
         end
         if (is_rgmii) begin
            rx_er_ff <= 1'b0;
         end
      end
   end

   // Collision and carrier sense, unused in RGMII and so held low there.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         col_ff <= 1'b0;
         crs_ff <= 1'b0;
      end else begin
         col_ff <= mac_pins & ~full_duplex_i & tx_act_ff & rx_ctl_ff;
         if (!mac_pins) begin
            crs_ff <= 1'b0;
         end else if (!full_duplex_i) begin
            crs_ff <= tx_act_ff | rx_ctl_ff;
         end else begin
            crs_ff <= rx_ctl_ff & (speed_i != phy_mac_pkg::SPD_1000);
         end
      end
   end

   assign tx_clk_o = tx_clk_ff;
   assign rx_clk_o = rx_clk_ff;
   assign rxd_o = rxd_ff;
   assign rx_ctl_o = rx_ctl_ff;
   assign rx_er_o = rx_er_ff;
   assign col_o = col_ff;
   assign crs_o = crs_ff;
   assign tx_sym_valid_o = sym_valid_ff;
   assign tx_sym_o = sym_ff;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   property p_gmii_tx_sample;
      is_gmii && gtx_rise && pin_s3_ff.en && !pin_s3_ff.er |=> tx_sym_valid_o &&
         tx_sym_o.kind == phy_mac_pkg::SYM_DATA && tx_sym_o.data == $past(pin_s3_ff.d);
   endproperty
   a_gmii_tx_sample: assert property (p_gmii_tx_sample)
      else $error("GMII transmit byte not taken on clock rise");

   property p_gmii_tx_inv;
      is_gmii && u_fire && u_en && u_er |=>
         tx_sym_valid_o && tx_sym_o.kind == phy_mac_pkg::SYM_INVALID;
   endproperty
   a_gmii_tx_inv: assert property (p_gmii_tx_inv)
      else $error("GMII transmit error did not give an invalid code-group");

   property p_mii_halt;
      is_mii && u_fire && u_en && u_er && err_seen_ff |=>
         tx_sym_o.kind == phy_mac_pkg::SYM_HALT;
   endproperty
   a_mii_halt: assert property (p_mii_halt)
      else $error("MII held error did not give Halt");

   property p_mii_inv_first;
      is_mii && u_fire && u_en && u_er && !err_seen_ff |=>
         tx_sym_o.kind == phy_mac_pkg::SYM_INVALID;
   endproperty
   a_mii_inv_first: assert property (p_mii_inv_first)
      else $error("MII error did not start with an invalid symbol");

   property p_rgmii_tx;
      is_rgmii && gtx_fall && rg_ctl_r_ff && pin_s3_ff.en |=> tx_sym_valid_o &&
         tx_sym_o.kind == phy_mac_pkg::SYM_DATA && tx_sym_o.data[3:0] == $past(rg_lo_ff);
   endproperty
   a_rgmii_tx: assert property (p_rgmii_tx)
      else $error("RGMII transmit byte wrong");

   property p_rx_clk_10;
      $rose(rx_clk_o) && speed_i == phy_mac_pkg::SPD_10 && $stable(speed_i) |->
         rx_clk_o [*8] ##1 !rx_clk_o;
   endproperty
   a_rx_clk_10: assert property (p_rx_clk_10)
      else $error("Receive clock half period wrong at 10 Mb/s");

   property p_gmii_rx;
      is_gmii && rx_fall && rq_valid |=> rx_ctl_o && rxd_o == $past(rq.data);
   endproperty
   a_gmii_rx: assert property (p_gmii_rx)
      else $error("GMII receive byte or valid wrong");

   property p_rxd_hi;
      !is_gmii |=> rxd_o[7:4] == phy_mac_pkg::NIB_ZERO;
   endproperty
   a_rxd_hi: assert property (p_rxd_hi)
      else $error("Upper receive bits active outside GMII");

   property p_rgmii_ctl;
      is_rgmii && speed_i == phy_mac_pkg::SPD_1000 && rx_fall && rq_valid && rq.err |=>
         rx_ctl_o ##1 !rx_ctl_o;
   endproperty
   a_rgmii_ctl: assert property (p_rgmii_ctl)
      else $error("RGMII receive control edge coding wrong");

   property p_rx_er_rgmii;
      is_rgmii |=> !rx_er_o;
   endproperty
   a_rx_er_rgmii: assert property (p_rx_er_rgmii)
      else $error("Receive error pin active in RGMII");

   property p_col_half;
      mac_pins && !full_duplex_i && tx_act_ff && rx_ctl_o |=> col_o;
   endproperty
   a_col_half: assert property (p_col_half)
      else $error("Collision missed in half duplex");

   property p_col_full;
      full_duplex_i |=> !col_o;
   endproperty
   a_col_full: assert property (p_col_full)
      else $error("Collision high in full duplex");

   property p_crs_half;
      mac_pins && !full_duplex_i && (tx_act_ff || rx_ctl_o) |=> crs_o;
   endproperty
   a_crs_half: assert property (p_crs_half)
      else $error("Carrier sense missed in half duplex");

   property p_crs_fd;
      mac_pins && full_duplex_i && speed_i != phy_mac_pkg::SPD_1000 |=>
         crs_o == $past(rx_ctl_o);
   endproperty
   a_crs_fd: assert property (p_crs_fd)
      else $error("Full duplex carrier sense not following receive");

   property p_tx_clk_off;
      !is_mii |=> !tx_clk_o;
   endproperty
   a_tx_clk_off: assert property (p_tx_clk_off)
      else $error("Transmit clock running outside MII");

   c_gmii_frame: cover property (is_gmii && rx_ctl_o ##1 rx_ctl_o ##1 !rx_ctl_o);
   c_mii_halt: cover property (tx_sym_valid_o && tx_sym_o.kind == phy_mac_pkg::SYM_HALT);
   c_rgmii_tx: cover property (is_rgmii && tx_sym_valid_o);
   c_fifo_full: cover property (!line_rx_ready_o);
endmodule // phy_mac_side_interface

// File: mac_model.sv
// MAC partner model: free running transmit clock and transmit pins.
// Assumes the bench calls send_unit() and keeps mode_i equal to the PHY's mode.
`timescale 1ns/1ps

module mac_model (
   // PHY side.
   input wire phy_mac_pkg::if_mode_e mode_i,
   input wire logic tx_clk_i,
   // MAC transmit pins.
   output logic gtx_clk_o,
   output logic [7:0] txd_o,
   output logic tx_ctl_o,
   output logic tx_er_o
);
   // The 200 ns clock is offset so that it has no phase tie to the system clock.
   initial begin
      gtx_clk_o = 1'b0;
      txd_o = 8'h00;
      tx_ctl_o = 1'b0;
      tx_er_o = 1'b0;
      #7;
      forever #100 gtx_clk_o = ~gtx_clk_o;
   end

   // One unit per call; idle units carry inverted junk so stale data never looks valid.
   task automatic send_unit(input logic [7:0] d, input logic en, input logic er);
      logic [7:0] v;
      v = en ? d : ~txd_o;
      if (mode_i == phy_mac_pkg::MODE_MII) begin
         @(posedge tx_clk_i);
         #1;
         txd_o <= {4'h0, v[3:0]};
         tx_ctl_o <= en;
         tx_er_o <= er;
      end else if (mode_i == phy_mac_pkg::MODE_GMII) begin
         @(negedge gtx_clk_o);
         #50;
         txd_o <= v;
         tx_ctl_o <= en;
         tx_er_o <= er;
         @(posedge gtx_clk_o);
      end else begin
         @(negedge gtx_clk_o);
         #50;
         txd_o <= {4'h0, v[3:0]};
         tx_ctl_o <= en;
         tx_er_o <= ~er;
         @(posedge gtx_clk_o);
         #50;
         txd_o <= {4'h0, v[7:4]};
         tx_ctl_o <= en ^ er;
      end
   endtask
endmodule // mac_model

// File: phy_mac_side_interface_bench.sv
// Bench for the PHY MAC-side interface: scoreboards on transmit units and receive pins.
// Assumes the package, the design and mac_model.sv are compiled before it.
`timescale 1ns/1ps

module phy_mac_side_interface_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   phy_mac_pkg::if_mode_e mode = phy_mac_pkg::MODE_GMII;
   phy_mac_pkg::speed_e speed = phy_mac_pkg::SPD_1000;
   logic fdx = 1'b1;
   logic lv = 1'b0;
   phy_mac_pkg::rx_word_s lw = '0;
   logic gtx, tx_ctl, tx_er, tx_clk, rx_clk, rx_ctl, rx_er, col, crs, sym_v, lrdy;
   logic [7:0] txd, rxd;
   phy_mac_pkg::tx_sym_s sym;
   phy_mac_pkg::tx_sym_s tx_exp[$];
   logic [8:0] rx_exp[$];
   logic rx_q = 1'b0, tx_q = 1'b0, col_seen = 1'b0, crs_seen = 1'b0, full_seen = 1'b0;
   logic rx_ctl_q = 1'b0;
   logic [8:0] rx_seen_q = '0;
   int rx_cnt = 0, tx_cnt = 0, rx_per = 0, tx_per = 0, bad_count = 0, tests_run = 0;
   logic [31:0] rnd = 32'h1fc2;

   // System clock, 25 ns period.
   always #12.5 clk = ~clk;

   phy_mac_side_interface phy_mac_side_interface_i (.clk_i(clk), .rst_b_i(rst_b),
      .mode_i(mode), .speed_i(speed), .full_duplex_i(fdx), .gtx_clk_i(gtx), .txd_i(txd),
      .tx_ctl_i(tx_ctl), .tx_er_i(tx_er), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .rxd_o(rxd),
      .rx_ctl_o(rx_ctl), .rx_er_o(rx_er), .col_o(col), .crs_o(crs), .tx_sym_valid_o(sym_v),
      .tx_sym_o(sym), .line_rx_valid_i(lv), .line_rx_word_i(lw), .line_rx_ready_o(lrdy));
   mac_model mac_model_i (.mode_i(mode), .tx_clk_i(tx_clk), .gtx_clk_o(gtx), .txd_o(txd),
      .tx_ctl_o(tx_ctl), .tx_er_o(tx_er));

   // Counts every comparison and reports each mismatch at once.
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Transmit scoreboard; a unit that nobody sent fails by itself.
   always @(posedge clk) begin
      if (rst_b === 1'b1 && sym_v === 1'b1) begin
         if (tx_exp.size() == 0) check(12'h000, 12'hfff);
         else check(sym, tx_exp.pop_front());
      end
   end

   // Receive watcher: takes the pins as they stood just before each receive clock rise.
   // RGMII changes its second half at the rise itself, so the delayed copy matters there.
   always @(posedge clk) begin
      rx_q <= rx_clk;
      rx_ctl_q <= rx_ctl;
      rx_seen_q <= {rx_er, rxd};
      tx_q <= tx_clk;
      rx_cnt <= rx_cnt + 1;
      tx_cnt <= tx_cnt + 1;
      if (col === 1'b1) col_seen <= 1'b1;
      if (crs === 1'b1) crs_seen <= 1'b1;
      if (lv === 1'b1 && lrdy === 1'b0) full_seen <= 1'b1;
      if (tx_clk === 1'b1 && tx_q === 1'b0) begin
         tx_per <= tx_cnt;
         tx_cnt <= 1;
      end
      if (rx_clk === 1'b1 && rx_q === 1'b0) begin
         rx_per <= rx_cnt;
         rx_cnt <= 1;
         if (rx_ctl_q === 1'b1 && rx_exp.size() == 0) begin
            check(12'h000, 12'hfff);
         end else if (rx_ctl_q === 1'b1) begin
            check({3'h0, rx_seen_q}, {3'h0, rx_exp.pop_front()});
         end
      end
   end

   // Notes the line-side unit, then lets the MAC model send it.
   task automatic tx_unit(input logic [7:0] d, input logic er, input phy_mac_pkg::sym_kind_e k);
      logic mii;
      mii = (mode == phy_mac_pkg::MODE_MII);
      tx_exp.push_back('{kind: k, data: mii ? {4'h0, d[3:0]} : d, nibble: mii});
      mac_model_i.send_unit(d, 1'b1, er);
   endtask

   // Offers one line word and holds it until the FIFO takes it.
   task automatic rx_word(input logic er, input logic [7:0] d);
      lv <= 1'b1;
      lw <= '{err: er, data: d};
      @(posedge clk);
      for (int i = 0; i < 400 && lrdy !== 1'b1; i++) @(posedge clk);
      if (mode == phy_mac_pkg::MODE_MII) begin
         rx_exp.push_back({er, 4'h0, d[3:0]});
         rx_exp.push_back({er, 4'h0, d[7:4]});
      end else if (mode == phy_mac_pkg::MODE_RGMII) begin
         // Before the rise the control line carries valid alone and the error pin stays low.
         rx_exp.push_back({1'b0, 4'h0, d[3:0]});
      end else rx_exp.push_back({er, d});
   endtask

   // One scenario: transmit units with an error run, receive words alongside.
   task automatic run(input phy_mac_pkg::if_mode_e m, input phy_mac_pkg::speed_e s,
         input logic f, input int ntx, input int nrx);
      logic er;
      @(posedge clk);
      mode <= m;
      speed <= s;
      fdx <= f;
      repeat (8) @(posedge clk);
      col_seen <= 1'b0;
      crs_seen <= 1'b0;
      full_seen <= 1'b0;
      fork
         begin
            for (int i = 0; i < ntx; i++) begin
               rnd = lfsr(rnd);
               er = (i == 2) || (m == phy_mac_pkg::MODE_MII && i > 2 && i < 5);
               tx_unit(rnd[7:0], er, !er ? phy_mac_pkg::SYM_DATA :
                  (i == 2 ? phy_mac_pkg::SYM_INVALID : phy_mac_pkg::SYM_HALT));
            end
            mac_model_i.send_unit(8'h00, 1'b0, 1'b0);
         end
         begin
            for (int i = 0; i < nrx; i++) rx_word(i == 1, rnd[15:8] ^ i[7:0]);
            lv <= 1'b0;
         end
      join
      for (int i = 0; i < 3000 && tx_exp.size() + rx_exp.size() > 0; i++) @(posedge clk);
      // A few spare cycles let the last pins and status flags settle.
      repeat (40) @(posedge clk);
      check(12'(tx_exp.size() + rx_exp.size()), 12'h000);
   endtask

   // Main sequence: reset, then GMII, RGMII, MII at 10 and MII at 100.
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      run(phy_mac_pkg::MODE_GMII, phy_mac_pkg::SPD_1000, 1'b1, 6, 4);
      check(12'(col_seen), 12'h000);
      check(12'(crs_seen), 12'h000);
      check(12'(rx_per), 12'(2 * phy_mac_pkg::HALF_1000));
      run(phy_mac_pkg::MODE_RGMII, phy_mac_pkg::SPD_1000, 1'b0, 5, 4);
      check(12'(col_seen), 12'h000);
      check(12'(crs_seen), 12'h000);
      run(phy_mac_pkg::MODE_MII, phy_mac_pkg::SPD_10, 1'b0, 8, 18);
      check(12'(full_seen), 12'h001);
      check(12'(col_seen), 12'h001);
      check(12'(crs_seen), 12'h001);
      check(12'(rx_per), 12'(2 * phy_mac_pkg::HALF_10));
      check(12'(tx_per), 12'(2 * phy_mac_pkg::HALF_10));
      run(phy_mac_pkg::MODE_MII, phy_mac_pkg::SPD_100, 1'b1, 0, 3);
      check(12'(col_seen), 12'h000);
      check(12'(crs_seen), 12'h001);
      check(12'(rx_per), 12'(2 * phy_mac_pkg::HALF_100));
      tally_and_finish();
   end

   // Watchdog: the scenarios need under 5,000 cycles, this allows 20,000.
   initial begin
      #500_000;
      bad_count++;
      tally_and_finish();
   end
endmodule // phy_mac_side_interface_bench
